//--- rtl/tally_params.svh
// Notes on behaviour
// - two counters, 0 and 1; a selector steers config and readback
// - each counter increments on its chosen source from the shared list
// - increment qualified as level low/high, falling, rising or any edge
// - start event fires when count reaches the delay count
// - end event fires when count reaches the duration count
// - start trigger and clear source exclusive; picking one turns other off
// - counting begins when the chosen start trigger fires
// - start trigger qualified by its own activation setting
// - chosen clear source zeroes the counter and puts it back in the active state
// - clear source qualified by its own activation setting
// - current count and state readable per counter
// - count just before a clear is captured into a readable register
// - state is idle, trigger wait, active, completed or overflow
`ifndef TALLY_PARAMS_SVH
`define TALLY_PARAMS_SVH

`define A_SELECT      8'h00
`define A_INC_SRC     8'h04
`define A_INC_ACT     8'h08
`define A_DELAY       8'h0c
`define A_DURATION    8'h10
`define A_TRIG_SRC    8'h14
`define A_TRIG_ACT    8'h18
`define A_CLR_SRC     8'h1c
`define A_CLR_ACT     8'h20
`define A_COUNT       8'h24
`define A_STATE       8'h28
`define A_CAPTURED    8'h2c
`define A_IRQ_STATUS  8'h30
`define A_IRQ_MASK    8'h34

`define IRQ_START_LSB 0
`define IRQ_END_LSB   2
`define IRQ_CLR_LSB   4
`define IRQ_OVF_LSB   6

`define RST_COUNT     32'h0000_0000
`define RST_IRQ_MASK  8'h00
`define RESP_OKAY     2'b00
`define RESP_SLVERR   2'b10

`define TICK_NS       1000
`define CLK_NS        8
`define TICK_CYCLES   (`TICK_NS / `CLK_NS)

`endif

//--- rtl/tally_pkg.sv
package tally_pkg;

  typedef enum logic [4:0] {
    src_off,
    src_us_tick,
    src_line0,
    src_line1,
    src_line2,
    src_line3,
    src_user0,
    src_user1,
    src_user2,
    src_user3,
    src_c0_start,
    src_c1_start,
    src_c0_end,
    src_c1_end,
    src_logic0,
    src_logic1,
    src_exp_start,
    src_exp_end,
    src_frame_wait
  } source_sel_t;

  typedef enum logic [2:0] {
    act_level_low,
    act_level_high,
    act_falling,
    act_rising,
    act_any
  } activation_t;

  typedef enum logic [2:0] {
    st_idle,
    st_trigger_wait,
    st_active,
    st_completed,
    st_overflow
  } tally_state_t;

endpackage

//--- rtl/tally_core.sv
`timescale 1ns/100ps
`include "tally_params.svh"

module tally_core
  import tally_pkg::*;
(
  input  wire logic         mclk_i,
  input  wire logic         resetn_i,
  input  wire logic         rearm_i,
  input  wire logic         trig_used_i,
  input  wire logic         inc_i,
  input  wire logic         trig_i,
  input  wire logic         clr_i,
  input  wire logic [31:0]  delay_i,
  input  wire logic [31:0]  duration_i,
  input  wire logic         cap_we_i,
  input  wire logic [31:0]  cap_data_i,
  output logic      [31:0]  count_o,
  output tally_state_t      state_o,
  output logic      [31:0]  captured_o,
  output logic              start_o,
  output logic              end_o,
  output logic              clear_o,
  output logic              overflow_o
);

  logic [31:0] count_nxt;
  logic        step;
  logic        wrap;

  assign step      = (state_o == st_active) && inc_i;
  assign wrap      = (count_o == 32'hffff_ffff);
  assign count_nxt = count_o + 32'h0000_0001;

  // ****************************************
  // state and count
  // ****************************************
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_o <= st_idle;
      count_o <= `RST_COUNT;
    end else if (rearm_i) begin
      state_o <= st_idle;
      count_o <= `RST_COUNT;
    end else if (clr_i) begin
      state_o <= st_active;
      count_o <= `RST_COUNT;
    end else begin
      case (state_o)
        st_idle: begin
          state_o <= trig_used_i ? st_trigger_wait : st_active;
        end
        st_trigger_wait: begin
          if (trig_i) begin
            state_o <= st_active;
            count_o <= `RST_COUNT;
          end
        end
        st_active: begin
          if (step && wrap) begin
            state_o <= st_overflow;
            count_o <= `RST_COUNT;
          end else if (step) begin
            count_o <= count_nxt;
            if (duration_i != 32'h0 && count_nxt == duration_i) begin
              state_o <= st_completed;
            end
          end
        end
        st_completed: state_o <= st_completed;
        st_overflow:  state_o <= st_overflow;
        default:      state_o <= st_idle;
      endcase
    end
  end

  // ****************************************
  // event pulses
  // ****************************************
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      start_o    <= 1'b0;
      end_o      <= 1'b0;
      clear_o    <= 1'b0;
      overflow_o <= 1'b0;
    end else begin
      start_o    <= !rearm_i && !clr_i && step && !wrap &&
                    delay_i != 32'h0 && count_nxt == delay_i;
      end_o      <= !rearm_i && !clr_i && step && !wrap &&
                    duration_i != 32'h0 && count_nxt == duration_i;
      clear_o    <= !rearm_i && clr_i;
      overflow_o <= !rearm_i && !clr_i && step && wrap;
    end
  end

  // ****************************************
  // value captured at clear
  // ****************************************
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      captured_o <= `RST_COUNT;
    end else if (clr_i && !rearm_i) begin
      captured_o <= count_o;
    end else if (cap_we_i) begin
      captured_o <= cap_data_i;
    end
  end

endmodule

//--- rtl/dual_event_counter_timer.sv
`timescale 1ns/100ps
`include "tally_params.svh"

module dual_event_counter_timer
  import tally_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        resetn_i,
  input  wire logic [3:0]  line_i,
  input  wire logic [3:0]  user_output_i,
  input  wire logic [1:0]  logic_block_i,
  input  wire logic        exposure_start_i,
  input  wire logic        exposure_end_i,
  input  wire logic        frame_trigger_wait_i,
  output logic      [1:0]  start_pulse_o,
  output logic      [1:0]  end_pulse_o,
  output logic             irq_o,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic      [1:0]  s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic      [31:0] s_axi_rdata_o,
  output logic      [1:0]  s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i
);

  localparam logic [6:0] TICK_LAST = 7'(`TICK_CYCLES - 1);

  // ****************************************
  // functions
  // ****************************************
  function automatic logic qualify(input logic [18:0] cur,
                                   input logic [18:0] prev,
                                   input source_sel_t sel,
                                   input activation_t act);
    logic c;
    logic p;
    logic q;
    c = 1'b0;
    p = 1'b0;
    if (sel != src_off && sel <= src_frame_wait) begin
      c = cur[sel];
      p = prev[sel];
    end
    case (act)
      act_level_low:  q = !c;
      act_level_high: q = c;
      act_falling:    q = p && !c;
      act_rising:     q = !p && c;
      act_any:        q = p ^ c;
      default:        q = 1'b0;
    endcase
    return q && (sel != src_off) && (sel <= src_frame_wait);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ****************************************
  // configuration state
  // ****************************************
  logic        sel_r;
  source_sel_t inc_src_r  [2];
  activation_t inc_act_r  [2];
  source_sel_t trig_src_r [2];
  activation_t trig_act_r [2];
  source_sel_t clr_src_r  [2];
  activation_t clr_act_r  [2];
  logic [31:0] delay_r    [2];
  logic [31:0] duration_r [2];
  logic [1:0]  rearm_r;
  logic [7:0]  irq_status_r;
  logic [7:0]  irq_mask_r;

  // ****************************************
  // bus slave state
  // ****************************************
  logic        aw_held_r;
  logic [7:0]  awaddr_r;
  logic        w_held_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        aw_take;
  logic        w_take;
  logic        wr_go;
  logic        ar_take;
  logic        wr_ok;
  logic [31:0] rd_data;
  logic        rd_ok;

  // ****************************************
  // counter cores and sources
  // ****************************************
  logic [6:0]   tick_cnt_r;
  logic         tick_r;
  logic [18:0]  src_vec;
  logic [18:0]  src_prev_r;
  logic [1:0]   inc_q;
  logic [1:0]   trig_q;
  logic [1:0]   clr_q;
  logic [1:0]   clear_w;
  logic [1:0]   ovf_w;
  logic [1:0]   cap_we;
  logic [31:0]  count_w    [2];
  tally_state_t state_w    [2];
  logic [31:0]  captured_w [2];

  // microsecond tick from the system clock
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tick_cnt_r <= 7'h00;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r == TICK_LAST) begin
      tick_cnt_r <= 7'h00;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 7'h01;
      tick_r     <= 1'b0;
    end
  end

  // own start/end pulses are core flops, so they arrive one cycle late
  assign src_vec = {frame_trigger_wait_i,
                    exposure_end_i,
                    exposure_start_i,
                    logic_block_i,
                    end_pulse_o,
                    start_pulse_o,
                    user_output_i,
                    line_i,
                    tick_r,
                    1'b0};

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      src_prev_r <= 19'h00000;
    end else begin
      src_prev_r <= src_vec;
    end
  end

  for (genvar gi = 0; gi < 2; gi++) begin : g_core
    assign inc_q[gi]  = qualify(src_vec, src_prev_r,
                                inc_src_r[gi], inc_act_r[gi]);
    assign trig_q[gi] = qualify(src_vec, src_prev_r,
                                trig_src_r[gi], trig_act_r[gi]);
    assign clr_q[gi]  = qualify(src_vec, src_prev_r,
                                clr_src_r[gi], clr_act_r[gi]);
    assign cap_we[gi] = wr_go && awaddr_r == `A_CAPTURED && sel_r == 1'(gi);

    tally_core u_core (
      .mclk_i      (mclk_i),
      .resetn_i    (resetn_i),
      .rearm_i     (rearm_r[gi]),
      .trig_used_i (trig_src_r[gi] != src_off),
      .inc_i       (inc_q[gi]),
      .trig_i      (trig_q[gi]),
      .clr_i       (clr_q[gi]),
      .delay_i     (delay_r[gi]),
      .duration_i  (duration_r[gi]),
      .cap_we_i    (cap_we[gi]),
      .cap_data_i  (merge(captured_w[gi], wdata_r, wstrb_r)),
      .count_o     (count_w[gi]),
      .state_o     (state_w[gi]),
      .captured_o  (captured_w[gi]),
      .start_o     (start_pulse_o[gi]),
      .end_o       (end_pulse_o[gi]),
      .clear_o     (clear_w[gi]),
      .overflow_o  (ovf_w[gi])
    );
  end

  // ****************************************
  // write channel
  // ****************************************
  assign aw_take = s_axi_awvalid_i && s_axi_awready_o;
  assign w_take  = s_axi_wvalid_i && s_axi_wready_o;
  assign wr_go   = aw_held_r && w_held_r && !s_axi_bvalid_o;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_held_r       <= 1'b0;
      w_held_r        <= 1'b0;
      awaddr_r        <= 8'h00;
      wdata_r         <= 32'h0000_0000;
      wstrb_r         <= 4'h0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= `RESP_OKAY;
    end else begin
      if (aw_take) begin
        awaddr_r <= s_axi_awaddr_i;
      end
      if (w_take) begin
        wdata_r <= s_axi_wdata_i;
        wstrb_r <= s_axi_wstrb_i;
      end
      aw_held_r       <= !wr_go && (aw_held_r || aw_take);
      w_held_r        <= !wr_go && (w_held_r || w_take);
      s_axi_awready_o <= wr_go || !(aw_held_r || aw_take);
      s_axi_wready_o  <= wr_go || !(w_held_r || w_take);
      if (wr_go) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  always_comb begin
    case (awaddr_r)
      `A_SELECT, `A_INC_SRC, `A_INC_ACT, `A_DELAY, `A_DURATION,
      `A_TRIG_SRC, `A_TRIG_ACT, `A_CLR_SRC, `A_CLR_ACT,
      `A_CAPTURED, `A_IRQ_STATUS, `A_IRQ_MASK: wr_ok = 1'b1;
      default:                                  wr_ok = 1'b0;
    endcase
  end

  // ****************************************
  // configuration registers
  // ****************************************
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sel_r   <= 1'b0;
      rearm_r <= 2'b00;
      for (int i = 0; i < 2; i++) begin
        inc_src_r[i]  <= src_off;
        inc_act_r[i]  <= act_rising;
        trig_src_r[i] <= src_off;
        trig_act_r[i] <= act_rising;
        clr_src_r[i]  <= src_off;
        clr_act_r[i]  <= act_rising;
        delay_r[i]    <= `RST_COUNT;
        duration_r[i] <= `RST_COUNT;
      end
    end else begin
      rearm_r <= 2'b00;
      if (wr_go) begin
        case (awaddr_r)
          `A_SELECT: begin
            if (wstrb_r[0]) sel_r <= wdata_r[0];
          end
          `A_INC_SRC: begin
            if (wstrb_r[0]) inc_src_r[sel_r] <= source_sel_t'(wdata_r[4:0]);
          end
          `A_INC_ACT: begin
            if (wstrb_r[0]) inc_act_r[sel_r] <= activation_t'(wdata_r[2:0]);
          end
          `A_DELAY: begin
            delay_r[sel_r] <= merge(delay_r[sel_r], wdata_r, wstrb_r);
          end
          `A_DURATION: begin
            duration_r[sel_r] <= merge(duration_r[sel_r], wdata_r, wstrb_r);
          end
          `A_TRIG_SRC: begin
            if (wstrb_r[0]) begin
              trig_src_r[sel_r] <= source_sel_t'(wdata_r[4:0]);
              rearm_r[sel_r]    <= 1'b1;
              if (wdata_r[4:0] != 5'h00) begin
                clr_src_r[sel_r] <= src_off;
              end
            end
          end
          `A_TRIG_ACT: begin
            if (wstrb_r[0]) trig_act_r[sel_r] <= activation_t'(wdata_r[2:0]);
          end
          `A_CLR_SRC: begin
            if (wstrb_r[0]) begin
              clr_src_r[sel_r] <= source_sel_t'(wdata_r[4:0]);
              rearm_r[sel_r]   <= 1'b1;
              if (wdata_r[4:0] != 5'h00) begin
                trig_src_r[sel_r] <= src_off;
              end
            end
          end
          `A_CLR_ACT: begin
            if (wstrb_r[0]) clr_act_r[sel_r] <= activation_t'(wdata_r[2:0]);
          end
          default: begin
            rearm_r <= 2'b00;
          end
        endcase
      end
    end
  end

  // ****************************************
  // read channel
  // ****************************************
  assign ar_take = s_axi_arvalid_i && s_axi_arready_o;

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b1;
    case (s_axi_araddr_i)
      `A_SELECT:     rd_data = {31'h0, sel_r};
      `A_INC_SRC:    rd_data = {27'h0, inc_src_r[sel_r]};
      `A_INC_ACT:    rd_data = {29'h0, inc_act_r[sel_r]};
      `A_DELAY:      rd_data = delay_r[sel_r];
      `A_DURATION:   rd_data = duration_r[sel_r];
      `A_TRIG_SRC:   rd_data = {27'h0, trig_src_r[sel_r]};
      `A_TRIG_ACT:   rd_data = {29'h0, trig_act_r[sel_r]};
      `A_CLR_SRC:    rd_data = {27'h0, clr_src_r[sel_r]};
      `A_CLR_ACT:    rd_data = {29'h0, clr_act_r[sel_r]};
      `A_COUNT:      rd_data = count_w[sel_r];
      `A_STATE:      rd_data = {29'h0, state_w[sel_r]};
      `A_CAPTURED:   rd_data = captured_w[sel_r];
      `A_IRQ_STATUS: rd_data = {24'h0, irq_status_r};
      `A_IRQ_MASK:   rd_data = {24'h0, irq_mask_r};
      default:       rd_ok   = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= `RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b1;
      s_axi_rdata_o   <= rd_data;
      s_axi_rresp_o   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid_o) begin
      s_axi_arready_o <= s_axi_rready_i;
      s_axi_rvalid_o  <= !s_axi_rready_i;
    end else begin
      s_axi_arready_o <= 1'b1;
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  logic [7:0] irq_set;
  logic [7:0] irq_clr;

  assign irq_set = {ovf_w, clear_w, end_pulse_o, start_pulse_o};
  assign irq_clr = (ar_take && s_axi_araddr_i == `A_IRQ_STATUS) ? 8'hff : 8'h00;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_status_r <= 8'h00;
      irq_mask_r   <= `RST_IRQ_MASK;
      irq_o        <= 1'b0;
    end else begin
      // a new event wins over the read that clears
      irq_status_r <= (irq_status_r & ~irq_clr) | irq_set;
      if (wr_go && awaddr_r == `A_IRQ_MASK && wstrb_r[0]) begin
        irq_mask_r <= wdata_r[7:0];
      end
      irq_o <= |(irq_status_r & irq_mask_r);
    end
  end

endmodule

//--- sim/tally_src_model.sv
`timescale 1ns/100ps
// ****************************************
// camera signal sources feeding the counters
// ****************************************
module tally_src_model (
  input  wire logic       mclk_i,
  input  wire logic [3:0] line_req_i,
  output logic      [3:0] line_o,
  output logic      [8:0] other_o
);
  initial begin
    line_o = 4'h0;
    other_o = 9'h000;
  end
  // lines follow the bench request one cycle late
  always @(posedge mclk_i) line_o <= line_req_i;
  // unselected sources keep moving so stray coupling shows up in counts
  always @(posedge mclk_i) other_o <= other_o + 9'h01b;
endmodule

//--- sim/dual_event_counter_timer_chk.sv
`timescale 1ns/100ps
`include "tally_params.svh"
module dual_event_counter_timer_chk (
  input wire logic        mclk_i,
  input wire logic        resetn_i,
  input wire logic [1:0]  start_pulse_o,
  input wire logic [1:0]  end_pulse_o,
  input wire logic [7:0]  s_axi_araddr_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0]  s_axi_rresp_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  // ****************************************
  // bus handshake and event pulse checks
  // ****************************************
  sequence s_rd_taken;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  sequence s_wr_taken;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o && !s_axi_bvalid_o;
  endsequence
  property p_rd_answer;
    s_rd_taken |=> s_axi_rvalid_o && !s_axi_arready_o;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_rd_unmapped;
    s_rd_taken ##0 (s_axi_araddr_i > 8'h37) |=> s_axi_rresp_o == `RESP_SLVERR && s_axi_rdata_o == 32'h0;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not refused");
  property p_rd_hold;
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data not held");
  property p_rd_release;
    s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o ##[0:1] s_axi_arready_o;
  endproperty
  a_rd_release: assert property (p_rd_release) else $error("read not released");
  property p_wr_answer;
    s_wr_taken |=> !s_axi_bvalid_o ##1 s_axi_bvalid_o;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer off");
  property p_wr_hold;
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write response not held");
  property p_start_pulse;
    start_pulse_o != 2'b00 |=> (start_pulse_o & $past(start_pulse_o)) == 2'b00;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
  property p_end_pulse;
    end_pulse_o != 2'b00 |=> (end_pulse_o & $past(end_pulse_o)) == 2'b00;
  endproperty
  a_end_pulse: assert property (p_end_pulse) else $error("end pulse too long");
endmodule
bind dual_event_counter_timer dual_event_counter_timer_chk i_chk (.*);

//--- sim/dual_event_counter_timer_test.sv
`timescale 1ns/100ps
`include "tally_params.svh"
module dual_event_counter_timer_test;
  import tally_pkg::*;
  logic        mclk_i, resetn_i, irq_o, slow, exposure_start_i, exposure_end_i;
  logic        frame_trigger_wait_i;
  logic [3:0]  line_i, line_req, user_output_i, s_axi_wstrb_i;
  logic [1:0]  logic_block_i, start_pulse_o, end_pulse_o;
  logic [8:0]  other;
  logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, seed, k, d, u, v;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, resp;
  logic        s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
  logic        s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o;
  logic        s_axi_rvalid_o, s_axi_rready_i;
  int          errors, n_checks, cyc, st_cyc, en_cyc, n_st, n_en;
  assign {user_output_i, logic_block_i, exposure_start_i, exposure_end_i,
          frame_trigger_wait_i} = other;
  assign s_axi_wstrb_i = 4'hf;
  tally_src_model i_src (.mclk_i(mclk_i), .line_req_i(line_req), .line_o(line_i), .other_o(other));
  dual_event_counter_timer i_dut (.*);
  initial begin
    mclk_i = 0;
    forever #4 mclk_i = ~mclk_i;
  end
  // ****************************************
  // checking and bus tasks
  // ****************************************
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cyc = cyc + 1;
    if (start_pulse_o[0] === 1'b1) begin
      n_st = n_st + 1;
      st_cyc = cyc;
    end
    if (end_pulse_o[0] === 1'b1) begin
      n_en = n_en + 1;
      en_cyc = cyc;
    end
    if (cyc == 20000) begin
      errors = errors + 1;
      final_report;
    end
  end
  task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    logic aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    slow = 1'($random(seed));
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= dat;
    s_axi_awvalid_i <= 1;
    s_axi_wvalid_i <= 1;
    while (!(aw_ok && w_ok)) begin
      @(posedge mclk_i);
      if (!aw_ok && s_axi_awready_o === 1'b1) begin
        aw_ok = 1;
        s_axi_awvalid_i <= 0;
      end
      if (!w_ok && s_axi_wready_o === 1'b1) begin
        w_ok = 1;
        s_axi_wvalid_i <= 0;
      end
    end
    if (slow) repeat (2) @(posedge mclk_i);
    s_axi_bready_i <= 1;
    do @(posedge mclk_i); while (s_axi_bvalid_o !== 1'b1);
    resp = s_axi_bresp_o;
    s_axi_bready_i <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    slow = 1'($random(seed));
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1;
    do @(posedge mclk_i); while (s_axi_arready_o !== 1'b1);
    s_axi_arvalid_i <= 0;
    if (slow) repeat (2) @(posedge mclk_i);
    s_axi_rready_i <= 1;
    do @(posedge mclk_i); while (s_axi_rvalid_o !== 1'b1);
    v = s_axi_rdata_o;
    resp = s_axi_rresp_o;
    s_axi_rready_i <= 0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string n);
    rd(a);
    chk32(n, e, v);
  endtask
  // n pulses away from the idle level on one line, then time to settle
  task automatic pulses(input int b, input logic idle, input logic [31:0] n);
    for (int i = 0; i < n; i++) begin
      line_req[b] <= ~idle;
      @(posedge mclk_i);
      line_req[b] <= idle;
      @(posedge mclk_i);
    end
    repeat (4) @(posedge mclk_i);
  endtask
  function automatic logic [31:0] exp_cnt(input int a, input logic [31:0] n);
    return (a == 4) ? n << 1 : n;
  endfunction
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    seed = 32'h9c7ecaa2;
    {errors, n_checks, cyc, n_st, n_en, st_cyc, en_cyc} = '0;
    {resetn_i, line_req, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = '0;
    {s_axi_arvalid_i, s_axi_rready_i, s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = '0;
    repeat (8) @(posedge mclk_i);
    resetn_i <= 1;
    repeat (2) @(posedge mclk_i);
    rdc(`A_INC_ACT, 32'(act_rising), "inc_act_reset");
    rdc(`A_IRQ_MASK, 32'(`RST_IRQ_MASK), "mask_reset");
    rdc(`A_STATE, 32'(st_active), "state_reset");
    rdc(`A_COUNT, `RST_COUNT, "count_reset");
    rd(8'h40);
    chk32("unmapped_rresp", 32'(`RESP_SLVERR), 32'(resp));
    wr(8'h44, 32'h1);
    chk32("unmapped_bresp", 32'(`RESP_SLVERR), 32'(resp));
    wr(`A_SELECT, 32'h0);
    for (int a = 0; a < 5; a++) begin
      k = ($random(seed) & 32'h7) + 1;
      wr(`A_INC_SRC, 32'(src_off));
      line_req[0] <= (a == 0);
      wr(`A_INC_ACT, 32'(a));
      wr(`A_CLR_SRC, 32'(src_off));
      wr(`A_INC_SRC, 32'(src_line0));
      pulses(0, a == 0, k);
      rdc(`A_COUNT, exp_cnt(a, k), "count_activation");
    end
    wr(`A_SELECT, 32'h1);
    wr(`A_INC_ACT, 32'(act_level_high));
    wr(`A_INC_SRC, 32'(src_c0_start));
    wr(`A_CLR_SRC, 32'(src_off));
    wr(`A_SELECT, 32'h0);
    wr(`A_INC_SRC, 32'(src_off));
    d = ($random(seed) & 32'h7) + 2;
    u = d + ($random(seed) & 32'hf) + 1;
    wr(`A_DELAY, d);
    wr(`A_DURATION, u);
    wr(`A_INC_ACT, 32'(act_level_high));
    wr(`A_CLR_SRC, 32'(src_off));
    rd(`A_IRQ_STATUS);
    n_st = 0;
    n_en = 0;
    wr(`A_INC_SRC, 32'(src_line0));
    line_req[0] <= 1;
    repeat (u + 8) @(posedge mclk_i);
    line_req[0] <= 0;
    chk32("start_events", 32'h1, 32'(n_st));
    chk32("end_events", 32'h1, 32'(n_en));
    chk32("start_to_end", u - d, 32'(en_cyc - st_cyc));
    rdc(`A_STATE, 32'(st_completed), "state_done");
    chk1("irq_masked", 1'b0, irq_o);
    wr(`A_IRQ_MASK, 32'h05);
    repeat (2) @(posedge mclk_i);
    chk1("irq_raised", 1'b1, irq_o);
    rdc(`A_IRQ_STATUS, 32'h05, "irq_status");
    repeat (2) @(posedge mclk_i);
    chk1("irq_cleared", 1'b0, irq_o);
    wr(`A_SELECT, 32'h1);
    rdc(`A_COUNT, 32'h1, "linked_count");
    wr(`A_TRIG_ACT, 32'(act_rising));
    wr(`A_TRIG_SRC, 32'(src_line1));
    @(posedge mclk_i);
    rdc(`A_STATE, 32'(st_trigger_wait), "state_wait");
    wr(`A_CLR_SRC, 32'(src_line2));
    rdc(`A_TRIG_SRC, 32'(src_off), "trigger_off");
    wr(`A_TRIG_SRC, 32'(src_line1));
    rdc(`A_CLR_SRC, 32'(src_off), "clear_off");
    pulses(1, 1'b0, 32'h1);
    rdc(`A_STATE, 32'(st_active), "state_triggered");
    k = ($random(seed) & 32'h7) + 1;
    wr(`A_INC_ACT, 32'(act_rising));
    wr(`A_INC_SRC, 32'(src_line3));
    wr(`A_CLR_ACT, 32'(act_rising));
    wr(`A_CLR_SRC, 32'(src_line2));
    pulses(3, 1'b0, k);
    pulses(2, 1'b0, 32'h1);
    rdc(`A_CAPTURED, k, "captured");
    rdc(`A_COUNT, 32'h0, "count_cleared");
    final_report;
  end
endmodule
